// ===== design/ocrt_clip.sv
// combinational clipper for the corrected bridge value
`default_nettype none
module ocrt_clip #(
    parameter int BW = ocrt_pkg::BRIDGE_W,
    parameter int CW = ocrt_pkg::CLIP_W
) (
    input wire logic [BW-1:0] value_in,
    input wire logic [CW-1:0] up_clip,
    input wire logic [CW-1:0] low_clip,
    output ocrt_pkg::ocrt_clip_t result
);
    logic [BW-1:0] up_thr;
    logic [BW-1:0] lo_thr;

    // thresholds built from the seven-bit fields
    assign up_thr = {ocrt_pkg::UP_TOP, up_clip, ocrt_pkg::UP_LOW};
    assign lo_thr = {ocrt_pkg::LO_TOP, low_clip, ocrt_pkg::LO_LOW};

    // unsigned compares; upper checked first, the two cannot both hold
    always_comb begin
        result.high_hit = value_in > up_thr;
        result.low_hit = value_in < lo_thr;
        if (result.high_hit) begin
            result.value = up_thr;
        end else if (result.low_hit) begin
            result.value = lo_thr;
        end else begin
            result.value = value_in;
        end
    end
endmodule : ocrt_clip
`default_nettype wire

// ===== design/ocrt_top.sv
// output stage control: clipping, converter feed, analog configuration, axi4-lite registers
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module ocrt_top #(
    parameter int BW = ocrt_pkg::BRIDGE_W,
    parameter int DW = ocrt_pkg::DAC_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [BW-1:0] corrected_bridge_value,
    input wire logic bridge_valid,
    output logic [DW-1:0] dac_code,
    output logic dac_update,
    output logic [BW-1:0] digital_out_value,
    output logic digital_out_valid,
    output ocrt_pkg::ocrt_analog_t analog_cfg,
    output logic [ocrt_pkg::TRIM_W-1:0] reference_trim_field,
    output logic regulator_coarse_field,
    input wire logic [ocrt_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ocrt_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // register state
    logic [31:0] config_reg;
    logic [31:0] next_config_reg;
    logic [ocrt_pkg::TRIM_W-1:0] trim_reg;
    logic [ocrt_pkg::TRIM_W-1:0] next_trim_reg;

    // bus state
    logic aw_held;
    logic next_aw_held;
    logic [ocrt_pkg::AXI_AW-1:0] aw_addr;
    logic [ocrt_pkg::AXI_AW-1:0] next_aw_addr;
    logic w_held;
    logic next_w_held;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp;
    logic next_bvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    logic next_awready;
    logic next_wready;
    logic next_arready;

    // datapath state
    logic [DW-1:0] next_dac_code;
    logic next_dac_update;
    logic [BW-1:0] next_digital_out_value;
    logic next_digital_out_valid;
    logic [BW-1:0] last_value;
    logic [BW-1:0] next_last_value;
    logic last_high;
    logic next_last_high;
    logic last_low;
    logic next_last_low;
    ocrt_pkg::ocrt_analog_t next_analog_cfg;
    logic [ocrt_pkg::TRIM_W-1:0] next_reference_trim_field;
    logic next_regulator_coarse_field;

    // decoded fields
    ocrt_pkg::ocrt_mode_t mode;
    ocrt_pkg::ocrt_clip_t clipped;
    logic [ocrt_pkg::CLIP_W-1:0] up_field;
    logic [ocrt_pkg::CLIP_W-1:0] low_field;
    logic [ocrt_pkg::DIAG_W-1:0] diag_field;

    // field views of the stored configuration word
    assign up_field = config_reg[ocrt_pkg::POS_UP_CLIP +: ocrt_pkg::CLIP_W];
    assign low_field = config_reg[ocrt_pkg::POS_LOW_CLIP +: ocrt_pkg::CLIP_W];
    assign diag_field = config_reg[ocrt_pkg::POS_DIAG +: ocrt_pkg::DIAG_W];
    assign mode = ocrt_pkg::ocrt_mode_t'(config_reg[ocrt_pkg::POS_MODE +: ocrt_pkg::MODE_W]);

    // clipper sees the corrected reading straight from the correction engine
    // thresholds follow config_reg; a write committing beside a sample takes effect from the next sample
    ocrt_clip #(
        .BW(BW),
        .CW(ocrt_pkg::CLIP_W)
    ) u_clip (
        .value_in(corrected_bridge_value),
        .up_clip(up_field),
        .low_clip(low_field),
        .result(clipped)
    );

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[8*i +: 8] = nw[8*i +: 8];
            end
        end
    endfunction : merge

    // axi4-lite slave; write completes once both address and data are held
    always_comb begin
        // hold everything unless a handshake below moves it
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid;
        next_config_reg = config_reg;
        next_trim_reg = trim_reg;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;

        // address and data channels are taken independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end

        // response leaves once the master has taken it
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end

        // commit only after the previous response is gone, so bresp never moves under bvalid
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ocrt_pkg::AXI_OKAY;
            unique case (aw_addr[ocrt_pkg::AXI_AW-1:2])
                ocrt_pkg::OFF_CONFIG[ocrt_pkg::AXI_AW-1:2]: begin
                    next_config_reg = merge(config_reg, w_data, w_strb);
                end
                ocrt_pkg::OFF_TRIM[ocrt_pkg::AXI_AW-1:2]: begin
                    if (w_strb[0]) begin
                        next_trim_reg = w_data[ocrt_pkg::POS_TRIM +: ocrt_pkg::TRIM_W];
                    end
                end
                default: begin
                    // result and status are read only
                    next_bresp = ocrt_pkg::AXI_SLVERR;
                end
            endcase
        end

        // read data leaves once the master has taken it
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end

        // read answer is registered; only the word index is decoded
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = ocrt_pkg::AXI_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr[ocrt_pkg::AXI_AW-1:2])
                ocrt_pkg::OFF_CONFIG[ocrt_pkg::AXI_AW-1:2]: begin
                    next_rdata = config_reg;
                end
                ocrt_pkg::OFF_TRIM[ocrt_pkg::AXI_AW-1:2]: begin
                    next_rdata[ocrt_pkg::POS_TRIM +: ocrt_pkg::TRIM_W] = trim_reg;
                end
                ocrt_pkg::OFF_RESULT[ocrt_pkg::AXI_AW-1:2]: begin
                    next_rdata[BW-1:0] = last_value;
                end
                ocrt_pkg::OFF_STATUS[ocrt_pkg::AXI_AW-1:2]: begin
                    next_rdata[ocrt_pkg::POS_SHORT_EN] = analog_cfg.short_limit_en;
                    next_rdata[ocrt_pkg::POS_HIGH_CLIP] = last_high;
                    next_rdata[ocrt_pkg::POS_LOW_HIT] = last_low;
                    next_rdata[ocrt_pkg::POS_REF_1V] = analog_cfg.ref_1v_sel;
                    next_rdata[ocrt_pkg::POS_COARSE_HI] = analog_cfg.coarse_high;
                    next_rdata[ocrt_pkg::POS_TRIM_RANK +: ocrt_pkg::TRIM_W] =
                        analog_cfg.trim_rank;
                end
                default: begin
                    next_rresp = ocrt_pkg::AXI_SLVERR;
                end
            endcase
        end

        // ready only while the holding slot is empty; keeps one write in flight
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // one clipped result per completed bridge calculation, sent to the converter or the serial output by mode
    always_comb begin
        // strobes are single pulses; values hold until the next sample
        next_dac_update = 1'b0;
        next_digital_out_valid = 1'b0;
        next_dac_code = dac_code;
        next_digital_out_value = digital_out_value;
        next_last_value = last_value;
        next_last_high = last_high;
        next_last_low = last_low;

        if (bridge_valid) begin
            next_last_value = clipped.value;
            next_last_high = clipped.high_hit;
            next_last_low = clipped.low_hit;
            unique case (mode)
                ocrt_pkg::OCRT_MODE_DIGITAL: begin
                    next_digital_out_value = clipped.value;
                    next_digital_out_valid = 1'b1;
                end
                default: begin
                    // top twelve of fourteen bits; the two dropped lsbs are below dac step
                    next_dac_code = clipped.value[BW-1 -: DW];
                    next_dac_update = 1'b1;
                end
            endcase
        end
    end

    // static analog configuration decoded from config_reg and trim_reg
    always_comb begin
        next_analog_cfg.short_limit_en = diag_field[ocrt_pkg::DIAG_SHORT_BIT];
        next_analog_cfg.coarse_high = config_reg[ocrt_pkg::POS_COARSE];
        next_analog_cfg.ref_1v_sel = mode == ocrt_pkg::OCRT_MODE_ONE_V;
        next_analog_cfg.trim_rank = ocrt_pkg::trim_rank(trim_reg);
        next_reference_trim_field = trim_reg;
        next_regulator_coarse_field = config_reg[ocrt_pkg::POS_COARSE];
    end

    // all state registers; clk_en freezes everything except the synchronous reset, which wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // readies stay low through reset so no request is taken early
            config_reg <= ocrt_pkg::RST_CONFIG;
            trim_reg <= ocrt_pkg::RST_TRIM;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bresp <= ocrt_pkg::AXI_OKAY;
            s_axi_bvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= ocrt_pkg::AXI_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            dac_code <= '0;
            dac_update <= 1'b0;
            digital_out_value <= '0;
            digital_out_valid <= 1'b0;
            last_value <= '0;
            last_high <= 1'b0;
            last_low <= 1'b0;
            analog_cfg <= '0;
            reference_trim_field <= ocrt_pkg::RST_TRIM;
            regulator_coarse_field <= 1'b0;
        end else if (clk_en) begin
            // clk_en low holds every flop, bus handshakes included
            config_reg <= next_config_reg;
            trim_reg <= next_trim_reg;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bresp <= next_bresp;
            s_axi_bvalid <= next_bvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            dac_code <= next_dac_code;
            dac_update <= next_dac_update;
            digital_out_value <= next_digital_out_value;
            digital_out_valid <= next_digital_out_valid;
            last_value <= next_last_value;
            last_high <= next_last_high;
            last_low <= next_last_low;
            analog_cfg <= next_analog_cfg;
            reference_trim_field <= next_reference_trim_field;
            regulator_coarse_field <= next_regulator_coarse_field;
        end
    end
endmodule : ocrt_top
`default_nettype wire

// ===== shared/ocrt_pkg.sv
// package of constants, types and field layouts for the output clip and reference trim block
`default_nettype none
package ocrt_pkg;
    localparam int BRIDGE_W = 14;
    localparam int CLIP_W = 7;
    localparam int DAC_W = 12;
    localparam int TRIM_W = 4;
    localparam int DIAG_W = 3;
    localparam int MODE_W = 2;
    localparam int AXI_AW = 4;
    // register byte offsets
    localparam logic [AXI_AW-1:0] OFF_CONFIG = 4'h0;
    localparam logic [AXI_AW-1:0] OFF_TRIM = 4'h4;
    localparam logic [AXI_AW-1:0] OFF_RESULT = 4'h8;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 4'hC;
    // config word field positions
    localparam int POS_UP_CLIP = 0;
    localparam int POS_LOW_CLIP = 8;
    localparam int POS_MODE = 16;
    localparam int POS_DIAG = 20;
    localparam int POS_COARSE = 24;
    // trim word and status positions
    localparam int POS_TRIM = 0;
    localparam int POS_SHORT_EN = 0;
    localparam int POS_HIGH_CLIP = 1;
    localparam int POS_LOW_HIT = 2;
    localparam int POS_REF_1V = 3;
    localparam int POS_COARSE_HI = 4;
    localparam int POS_TRIM_RANK = 8;
    // reset values and axi response codes
    localparam logic [31:0] RST_CONFIG = 32'h0000_7F00;
    localparam logic [TRIM_W-1:0] RST_TRIM = 4'h0;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // threshold padding patterns
    localparam logic [1:0] UP_TOP = 2'h3;
    localparam logic [4:0] UP_LOW = 5'h1F;
    localparam logic [1:0] LO_TOP = 2'h0;
    localparam logic [4:0] LO_LOW = 5'h00;
    // short limit enabled when diagnostic field bit 0 is set
    localparam int DIAG_SHORT_BIT = 0;

    typedef enum logic [MODE_W-1:0] {
        OCRT_MODE_RATIO = 2'h0,
        OCRT_MODE_ABS = 2'h1,
        OCRT_MODE_ONE_V = 2'h2,
        OCRT_MODE_DIGITAL = 2'h3
    } ocrt_mode_t;

    typedef struct packed {
        logic [BRIDGE_W-1:0] value;
        logic high_hit;
        logic low_hit;
    } ocrt_clip_t;

    typedef struct packed {
        logic short_limit_en;
        logic coarse_high;
        logic ref_1v_sel;
        logic [TRIM_W-1:0] trim_rank;
    } ocrt_analog_t;

    // rank 15 is highest voltage: code 1000 maps to 15, 0111 maps to 0
    function automatic logic [TRIM_W-1:0] trim_rank(input logic [TRIM_W-1:0] code);
        trim_rank = ~(code ^ 4'h8);
    endfunction : trim_rank
endpackage : ocrt_pkg
`default_nettype wire

// ===== tb/ocrt_checker.sv
// concurrent checks on the ports of the output clip and reference trim block
`default_nettype none
module ocrt_checker #(
    parameter int BW = 14,
    parameter int DW = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [BW-1:0] corrected_bridge_value,
    input wire logic bridge_valid,
    input wire logic [DW-1:0] dac_code,
    input wire logic dac_update,
    input wire logic [BW-1:0] digital_out_value,
    input wire logic digital_out_valid,
    input wire ocrt_pkg::ocrt_analog_t analog_cfg,
    input wire logic [ocrt_pkg::TRIM_W-1:0] reference_trim_field,
    input wire logic regulator_coarse_field
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // every strobe traces back to a bridge sample a cycle earlier; only the converter check also requires clk_en
    a_dac_cause: assert property (dac_update |-> $past(bridge_valid && clk_en))
        else $error("converter update without a bridge sample");
    a_serial_cause: assert property (digital_out_valid |-> $past(bridge_valid))
        else $error("serial output without a bridge sample");
    // one sample feeds the converter or the serial path, never both
    a_one_path: assert property (!(dac_update && digital_out_valid))
        else $error("both output paths fired");
    // values between the narrowest thresholds can never be clipped
    a_mid_pass: assert property (
        bridge_valid && clk_en && corrected_bridge_value >= 14'h0FE0
        && corrected_bridge_value <= 14'h301F |=>
        (dac_update && dac_code == $past(corrected_bridge_value[BW-1:2]))
        || (digital_out_valid && digital_out_value == $past(corrected_bridge_value)))
        else $error("in-range value was altered");
    // a lowered code must carry the upper threshold padding
    a_dac_high: assert property (
        dac_update && dac_code < $past(corrected_bridge_value[BW-1:2]) |->
        dac_code[DW-1:DW-2] == 2'h3 && dac_code[2:0] == 3'h7)
        else $error("upper clip pattern wrong");
    a_serial_low: assert property (
        digital_out_valid && digital_out_value > $past(corrected_bridge_value) |->
        digital_out_value[BW-1:BW-2] == 2'h0 && digital_out_value[4:0] == 5'h00)
        else $error("lower clip pattern wrong");
    a_code_hold: assert property (!dac_update |-> $stable(dac_code))
        else $error("converter code moved without update");
    a_freeze_hold: assert property (!clk_en |=> $stable(digital_out_value))
        else $error("serial value moved while frozen");
    // rank lags the trim copy by at most the config pipeline
    a_trim_rank: assert property ($changed(reference_trim_field) |->
        ##[0:2] analog_cfg.trim_rank == 4'h7 - reference_trim_field)
        else $error("trim rank does not follow code");
    a_coarse_same: assert property ($changed(regulator_coarse_field) |->
        ##[0:2] analog_cfg.coarse_high == regulator_coarse_field)
        else $error("coarse set point copies disagree");
endmodule : ocrt_checker
bind ocrt_top ocrt_checker #(.BW(BW), .DW(DW)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .corrected_bridge_value(corrected_bridge_value), .bridge_valid(bridge_valid),
    .dac_code(dac_code), .dac_update(dac_update), .digital_out_value(digital_out_value),
    .digital_out_valid(digital_out_valid), .analog_cfg(analog_cfg),
    .reference_trim_field(reference_trim_field), .regulator_coarse_field(regulator_coarse_field)
);
`default_nettype wire

// ===== tb/ocrt_partner.sv
// far-side model: output converter and serial output receiver
`default_nettype none
module ocrt_partner (
    input wire logic aclk,
    input wire logic [11:0] dac_code,
    input wire logic dac_update,
    input wire logic [13:0] digital_out_value,
    input wire logic digital_out_valid,
    output logic [13:0] seen,
    output int n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        seen = 14'h0000;
        n_out = 0;
    end
    // converter latches on its strobe; its two missing bits are below resolution
    always @(posedge aclk) begin
        if (dac_update === 1'b1) begin
            seen <= {dac_code, 2'h0};
            n_out <= n_out + 1;
        end else if (digital_out_valid === 1'b1) begin
            seen <= digital_out_value;
            n_out <= n_out + 1;
        end
    end
endmodule : ocrt_partner
`default_nettype wire

// ===== tb/test_output_clip_and_ref_trim.sv
// self-checking bench for the output clip and reference trim block
`default_nettype none
module test_output_clip_and_ref_trim;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    logic [13:0] corrected_bridge_value = 14'h0000;
    logic bridge_valid = 1'b0;
    logic [11:0] dac_code;
    logic dac_update;
    logic [13:0] digital_out_value;
    logic digital_out_valid;
    ocrt_pkg::ocrt_analog_t analog_cfg;
    logic [3:0] reference_trim_field;
    logic regulator_coarse_field;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [13:0] seen;
    int n_out;
    int mismatches = 0;
    int n_compared = 0;
    // clip cases: near and past both thresholds, in every output mode
    logic [6:0] ups [8] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h7F, 7'h7F, 7'h55, 7'h55};
    logic [6:0] los [8] = '{7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h00, 7'h00, 7'h2A, 7'h2A};
    logic [13:0] vals [8] = '{14'h3FFF, 14'h3020, 14'h0FDF, 14'h0FE0,
                              14'h3FFF, 14'h0000, 14'h3AC0, 14'h053F};
    always #2 aclk = ~aclk;
    ocrt_top u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .corrected_bridge_value(corrected_bridge_value), .bridge_valid(bridge_valid),
        .dac_code(dac_code), .dac_update(dac_update), .digital_out_value(digital_out_value),
        .digital_out_valid(digital_out_valid), .analog_cfg(analog_cfg),
        .reference_trim_field(reference_trim_field),
        .regulator_coarse_field(regulator_coarse_field),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ocrt_partner u_far (.aclk(aclk), .dac_code(dac_code), .dac_update(dac_update),
        .digital_out_value(digital_out_value), .digital_out_valid(digital_out_valid),
        .seen(seen), .n_out(n_out));
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task timeout(input string what);
        mismatches++;
        $display("wrong value %s expected answer seen timeout", what);
        end_of_test();
    endtask : timeout
    // write: both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 40) timeout("write response");
        bready <= 1'b0;
        check("write resp", er, bresp);
    endtask : axi_wr
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 40) timeout("read data");
        rready <= 1'b0;
        check(what, ed, rdata);
        check("read resp", er, rresp);
    endtask : rd_chk
    // one bridge sample; returns just after the output strobe lands
    task automatic send(input logic [13:0] v);
        int n;
        @(posedge aclk);
        corrected_bridge_value <= v;
        bridge_valid <= 1'b1;
        @(posedge aclk);
        bridge_valid <= 1'b0;
        for (n = 0; n < 8; n++) begin
            #1;
            if (dac_update === 1'b1 || digital_out_valid === 1'b1) break;
            @(posedge aclk);
        end
        if (n == 8) timeout("bridge output");
    endtask : send
    function automatic logic [13:0] clipv(input logic [13:0] v, input logic [6:0] u,
                                          input logic [6:0] l);
        logic [13:0] hi;
        logic [13:0] lo;
        hi = {2'h3, u, 5'h1F};
        lo = {2'h0, l, 5'h00};
        clipv = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction : clipv
    initial begin
        logic [13:0] e;
        logic [1:0] m;
        logic c;
        int i;
        int n_prev;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk("config", 4'h0, 32'h0000_7F00, 2'h0);
        rd_chk("status", 4'hC, 32'h0000_0700, 2'h0);
        rd_chk("unaligned", 4'h2, 32'h0000_7F00, 2'h0); // word index only, low bits ignored
        axi_wr(4'h8, 32'hFFFF_FFFF, 4'hF, 2'h2);
        rd_chk("result", 4'h8, 32'h0, 2'h0);
        $display("test reset and map done");
        for (i = 0; i < 8; i++) begin
            m = i[1:0];
            c = i[0];
            axi_wr(4'h0, {7'h00, c, 1'b0, i[2:0], 2'h0, m, 1'b0, los[i], 1'b0, ups[i]},
                   4'hF, 2'h0);
            repeat (2) @(posedge aclk);
            check("short limit", i[0], analog_cfg.short_limit_en);
            check("coarse", c, regulator_coarse_field);
            check("one volt ref", m == 2'h2, analog_cfg.ref_1v_sel);
            e = clipv(vals[i], ups[i], los[i]);
            send(vals[i]);
            if (m == 2'h3) check("serial value", e, digital_out_value);
            else check("converter code", e[13:2], dac_code);
            rd_chk("result", 4'h8, e, 2'h0);
            rd_chk("status", 4'hC, {20'h0, 4'h7, 3'h0, c, m == 2'h2, e > vals[i],
                   e < vals[i], i[0]}, 2'h0);
            check("far side", m == 2'h3 ? e : {e[13:2], 2'h0}, seen);
        end
        $display("test clipping done");
        for (i = 0; i < 16; i++) begin
            axi_wr(4'h4, i, 4'h1, 2'h0);
            repeat (2) @(posedge aclk);
            check("trim field", i, reference_trim_field);
            check("trim rank", 15 - ((i + 8) % 16), analog_cfg.trim_rank);
        end
        axi_wr(4'h4, 32'h3, 4'hE, 2'h0);
        rd_chk("trim kept", 4'h4, 32'hF, 2'h0);
        rd_chk("status", 4'hC, 32'h0000_0815, 2'h0);
        $display("test trim done");
        // a sample offered while frozen must not reach the output
        n_prev = n_out;
        @(posedge aclk);
        clk_en <= 1'b0;
        bridge_valid <= 1'b1;
        @(posedge aclk);
        bridge_valid <= 1'b0;
        repeat (3) @(posedge aclk);
        clk_en <= 1'b1;
        repeat (4) @(posedge aclk);
        check("frozen count", n_prev, n_out);
        $display("test freeze done");
        @(posedge aclk);
        bridge_valid <= 1'b1;
        corrected_bridge_value <= 14'h2000;
        @(posedge aclk);
        corrected_bridge_value <= 14'h2001;
        @(posedge aclk);
        bridge_valid <= 1'b0;
        repeat (3) @(posedge aclk);
        check("update count", n_prev + 2, n_out);
        check("serial value", 14'h2001, digital_out_value);
        $display("test back to back done");
        end_of_test();
    end
endmodule : test_output_clip_and_ref_trim
`default_nettype wire
